// ===== verilog/cmd_status.v
// command list sequencer and per-command result word memory
`timescale 1ns/1ns
`include "cmd_status_consts.vh"

// Summary of operation
// - remote codes 1,2,3 report as 0x1000, 0x2000, 0x3000.
// - remote codes 5,6,7 report as 0x5000, 0x6000, 0x7000.
// - remote codes 8,9,b report as 0x8000, 0x9000, 0xb000.
// - 0xa000 and 0xc000 both mean wait-ack; 0xd000, 0xe000 unused.
// - extended nibble gives result 0xf0 high byte, extended code low byte.
// - extended codes 0xf001, 0xf002, 0xf003 for field and level faults.
// - extended codes 0xf004, 0xf005, 0xf006 for symbol and address faults.
// - extended codes 0xf007, 0xf009, 0xf00a for size faults.
// - extended codes 0xf00b, 0xf010, 0xf01e for access faults.
// - extended codes 0xf011, 0xf012, 0xf017 for data type faults.
// - extended codes 0xf01a, 0xf01b, 0xf01f for ownership and temporary faults.
// - clear-to-send low at transmit start abandons command with 0xffff.
// - request transmit exceeding allowed time records 0xfffe.
// - missing link ack records 0xfff6; missing response records 0xfff5.
// - reply length differing from requested count on reads, or nonzero on writes, records 0xfff4.
// - nak received records 0xffec; nak sent while awaiting the response records 0xffeb.
// - network transport uses service address 0xaf12 at both ends.
// - writes source database data; reads store into database.
// - commands issue only by stepping through the user command list.
// - each entry's database location is the first database word used.
// - result word holds status in high byte, extended status in low.
// - one result word per list entry, written with that command's result.
module cmd_status (
    // clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // command list side
    input wire list_go_in,
    input wire [`CMD_IDX_W-1:0] list_len_in,
    input wire [`DB_ADDR_W-1:0] entry_db_addr_in,
    input wire [`LEN_W-1:0] entry_count_in,
    input wire entry_is_write_in,
    output reg [`CMD_IDX_W-1:0] entry_idx_out,
    output reg list_busy_out,
    // link engine side
    input wire cts_in,
    output reg req_start_out,
    output reg req_write_out,
    output reg [`LEN_W-1:0] req_count_out,
    output reg [15:0] net_service_out,
    input wire tx_done_in,
    input wire ack_in,
    input wire nak_in,
    input wire rsp_valid_in,
    input wire [7:0] remote_status_code_in,
    input wire [7:0] extended_status_byte_in,
    input wire [`LEN_W-1:0] rsp_len_in,
    input wire nak_sent_in,
    // database side
    output reg db_rd_out,
    output reg db_wr_out,
    output reg [`DB_ADDR_W-1:0] db_addr_out,
    // result memory read port
    input wire [`CMD_IDX_W-1:0] result_idx_in,
    output reg [15:0] result_word_out,
    output reg result_strobe_out
);

    localparam [31:0] TX_CYCLES = `TX_TIME_NS / `CLK_PERIOD_NS;
    localparam [31:0] ACK_CYCLES = `ACK_TIME_NS / `CLK_PERIOD_NS;
    localparam [31:0] RSP_CYCLES = `RSP_TIME_NS / `CLK_PERIOD_NS;

    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_START = 6'h02;
    localparam [5:0] ST_TX = 6'h04;
    localparam [5:0] ST_ACK = 6'h08;
    localparam [5:0] ST_RSP = 6'h10;
    localparam [5:0] ST_DONE = 6'h20;

    // cts is a pin level, so it is synchronised before use
    reg cts_meta;
    reg cts_sync;
    reg [5:0] state;
    reg [31:0] timer;
    reg [15:0] result;
    reg [`CMD_IDX_W-1:0] last_idx;
    reg [`LEN_W-1:0] want_len;
    reg [15:0] result_mem [0:`CMD_COUNT-1];
    integer i;

    // map a remote reply to its result word: status high, extended low
    function [15:0] map_remote;
        input [7:0] sts;
        input [7:0] ext;
        begin
            if (sts[`STS_HI:`STS_LO] == `NIBBLE_EXT) begin
                map_remote = {`RES_EXT_HIGH, ext};
            end else begin
                map_remote = {sts[`STS_HI:`STS_LO], 12'h000};
            end
        end
    endfunction

    // two-stage synchroniser for the modem line
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cts_meta <= 1'b0;
            cts_sync <= 1'b0;
        end else begin
            cts_meta <= cts_in;
            cts_sync <= cts_meta;
        end
    end

    // sequencer: one command at a time, walking the user list
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_IDLE;
            timer <= 32'h0;
            result <= 16'h0000;
            entry_idx_out <= {`CMD_IDX_W{1'b0}};
            last_idx <= {`CMD_IDX_W{1'b0}};
            want_len <= {`LEN_W{1'b0}};
            list_busy_out <= 1'b0;
            req_start_out <= 1'b0;
            req_write_out <= 1'b0;
            req_count_out <= {`LEN_W{1'b0}};
            net_service_out <= 16'h0000;
            db_rd_out <= 1'b0;
            db_wr_out <= 1'b0;
            db_addr_out <= {`DB_ADDR_W{1'b0}};
        end else begin
            req_start_out <= 1'b0;
            db_rd_out <= 1'b0;
            db_wr_out <= 1'b0;
            net_service_out <= `NET_SERVICE_ADDR;
            case (state)
                ST_IDLE: begin
                    if (list_go_in) begin
                        entry_idx_out <= {`CMD_IDX_W{1'b0}};
                        last_idx <= list_len_in - 1'b1;
                        list_busy_out <= 1'b1;
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    last_idx <= last_idx;
                    if (!cts_sync) begin
                        result <= `RES_NO_CTS;
                        state <= ST_DONE;
                    end else begin
                        req_start_out <= 1'b1;
                        req_write_out <= entry_is_write_in;
                        req_count_out <= entry_count_in;
                        want_len <= entry_is_write_in ? {`LEN_W{1'b0}} : entry_count_in;
                        db_addr_out <= entry_db_addr_in;
                        db_rd_out <= entry_is_write_in;
                        timer <= TX_CYCLES;
                        state <= ST_TX;
                    end
                end
                ST_TX: begin
                    if (tx_done_in) begin
                        timer <= ACK_CYCLES;
                        state <= ST_ACK;
                    end else if (timer == 32'h0) begin
                        result <= `RES_TX_TIMEOUT;
                        state <= ST_DONE;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                ST_ACK: begin
                    if (nak_in) begin
                        result <= `RES_NAK_RECEIVED;
                        state <= ST_DONE;
                    end else if (ack_in) begin
                        timer <= RSP_CYCLES;
                        state <= ST_RSP;
                    end else if (timer == 32'h0) begin
                        result <= `RES_ACK_TIMEOUT;
                        state <= ST_DONE;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                ST_RSP: begin
                    if (nak_sent_in) begin
                        result <= `RES_NAK_SENT;
                        state <= ST_DONE;
                    end else if (rsp_valid_in) begin
                        if (remote_status_code_in != 8'h00) begin
                            result <= map_remote(remote_status_code_in,
                                extended_status_byte_in);
                        end else if (rsp_len_in != want_len) begin
                            result <= `RES_COUNT_MISMATCH;
                        end else begin
                            result <= `RES_SUCCESS;
                            db_wr_out <= !req_write_out;
                        end
                        state <= ST_DONE;
                    end else if (timer == 32'h0) begin
                        result <= `RES_RSP_TIMEOUT;
                        state <= ST_DONE;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                ST_DONE: begin
                    // the result word is stored this cycle, then move on
                    if (entry_idx_out == last_idx) begin
                        list_busy_out <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        entry_idx_out <= entry_idx_out + 1'b1;
                        state <= ST_START;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // result memory: one word per entry, always overwritten
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (i = 0; i < `CMD_COUNT; i = i + 1) begin
                result_mem[i] <= 16'h0000;
            end
            result_word_out <= 16'h0000;
            result_strobe_out <= 1'b0;
        end else begin
            result_strobe_out <= (state == ST_DONE);
            if (state == ST_DONE) begin
                result_mem[entry_idx_out] <= result;
            end
            result_word_out <= result_mem[result_idx_in];
        end
    end

endmodule

// ===== verilog/cmd_status_consts.vh
// result codes, field positions and sizing for the command status block
`ifndef CMD_STATUS_CONSTS_VH
`define CMD_STATUS_CONSTS_VH
`define RES_SUCCESS 16'h0000
`define RES_ILLEGAL_CMD 16'h1000
`define RES_HOST_REFUSES 16'h2000
`define RES_HOST_MISSING 16'h3000
`define RES_HW_FAULT 16'h4000
`define RES_ADDR_PROTECT 16'h5000
`define RES_CMD_PROTECT 16'h6000
`define RES_PROGRAM_MODE 16'h7000
`define RES_COMPAT_ZONE 16'h8000
`define RES_NO_BUFFER 16'h9000
`define RES_WAIT_ACK_A 16'ha000
`define RES_DOWNLOAD 16'hb000
`define RES_WAIT_ACK_C 16'hc000
`define RES_UNUSED_D 16'hd000
`define RES_UNUSED_E 16'he000
`define RES_EXT_HIGH 8'hf0
`define NIBBLE_EXT 4'hf
`define EXT_ILLEGAL_FIELD 8'h01
`define EXT_FEW_LEVELS 8'h02
`define EXT_MANY_LEVELS 8'h03
`define EXT_SYM_NOT_FOUND 8'h04
`define EXT_SYM_FORMAT 8'h05
`define EXT_ADDR_UNUSABLE 8'h06
`define EXT_FILE_SIZE 8'h07
`define EXT_TOO_LARGE 8'h09
`define EXT_SIZE_PLUS_ADDR 8'h0a
`define EXT_PRIVILEGE 8'h0b
`define EXT_NO_ACCESS 8'h10
`define EXT_ILLEGAL_TYPE 8'h11
`define EXT_BAD_PARAM 8'h12
`define EXT_TYPE_MISMATCH 8'h17
`define EXT_FILE_OWNED 8'h1a
`define EXT_PROG_OWNED 8'h1b
`define EXT_ELEM_PROTECT 8'h1e
`define EXT_TEMP_PROBLEM 8'h1f
`define RES_NO_CTS 16'hffff
`define RES_TX_TIMEOUT 16'hfffe
`define RES_ACK_TIMEOUT 16'hfff6
`define RES_RSP_TIMEOUT 16'hfff5
`define RES_COUNT_MISMATCH 16'hfff4
`define RES_NAK_RECEIVED 16'hffec
`define RES_NAK_SENT 16'hffeb
`define NET_SERVICE_ADDR 16'haf12
`define STS_HI 7
`define STS_LO 4
`define CMD_IDX_W 4
`define CMD_COUNT 16
`define DB_ADDR_W 16
`define LEN_W 8
`define TX_TIME_NS 1000
`define ACK_TIME_NS 1500
`define RSP_TIME_NS 2000
`define CLK_PERIOD_NS 10
`endif

// ===== verif/cmd_status_checker.sv
// port checker for the command status block
`timescale 1ns/1ns
`include "cmd_status_consts.vh"
module cmd_status_checker (
    // clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // command list side
    input wire list_go_in,
    input wire [`CMD_IDX_W-1:0] list_len_in,
    input wire [`DB_ADDR_W-1:0] entry_db_addr_in,
    input wire [`LEN_W-1:0] entry_count_in,
    input wire entry_is_write_in,
    input wire [`CMD_IDX_W-1:0] entry_idx_out,
    input wire list_busy_out,
    // link and database side
    input wire cts_in,
    input wire req_start_out,
    input wire req_write_out,
    input wire [`LEN_W-1:0] req_count_out,
    input wire [15:0] net_service_out,
    input wire db_rd_out,
    input wire db_wr_out,
    input wire [`DB_ADDR_W-1:0] db_addr_out,
    input wire result_strobe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_service_addr: assert property ($past(reset_n_in) |-> net_service_out == 16'haf12)
        else $error("service address wrong");
    // four low samples outlast the two-flop synchroniser
    a_cts_gate: assert property (!cts_in [*4] |-> !req_start_out)
        else $error("request without clear to send");
    a_write_fetch: assert property (req_start_out |-> db_rd_out == req_write_out)
        else $error("database fetch does not follow direction");
    a_first_word: assert property (req_start_out |-> db_addr_out == entry_db_addr_in)
        else $error("first database word wrong");
    a_req_fields: assert property (req_start_out |->
        req_count_out == entry_count_in && req_write_out == entry_is_write_in)
        else $error("request fields differ from entry");
    a_go_starts: assert property ($rose(list_busy_out) |-> $past(list_go_in))
        else $error("walk started without go");
    a_req_in_walk: assert property (req_start_out |-> list_busy_out)
        else $error("request outside a walk");
    a_entry_range: assert property (list_busy_out && list_len_in != 4'h0 |->
        entry_idx_out < list_len_in)
        else $error("entry index past list end");
    a_store_read: assert property (db_wr_out |-> !req_write_out && list_busy_out)
        else $error("database store outside a read");
    a_end_strobe: assert property ($fell(list_busy_out) |-> result_strobe_out)
        else $error("walk ended without storing a result");
    c_request: cover property (req_start_out);
    c_store: cover property (db_wr_out);
    c_result: cover property (result_strobe_out);
endmodule
bind cmd_status cmd_status_checker i_chk (.clk_in, .reset_n_in, .list_go_in, .list_len_in,
    .entry_db_addr_in, .entry_count_in, .entry_is_write_in, .entry_idx_out, .list_busy_out,
    .cts_in, .req_start_out, .req_write_out, .req_count_out, .net_service_out, .db_rd_out,
    .db_wr_out, .db_addr_out, .result_strobe_out);

// ===== verif/link_model.sv
// far-side link engine model answering each request
`timescale 1ns/1ns
module link_model (
    // request side
    input wire clk_in,
    input wire req_in,
    input wire [2:0] mode_in,
    input wire [7:0] sts_in,
    input wire [7:0] ext_in,
    input wire [7:0] len_in,
    // answers
    output reg tx_done_out = 1'b0,
    output reg ack_out = 1'b0,
    output reg nak_out = 1'b0,
    output reg rsp_out = 1'b0,
    output reg nak_sent_out = 1'b0,
    output reg [7:0] sts_out = 8'h00,
    output reg [7:0] ext_out = 8'h00,
    output reg [7:0] len_out = 8'h00
);
    reg [1:0] step = 2'b00;
    // done, ack or nak, reply or nak sent; 1 nak, 2 nak sent, 3 no ack, 4 no reply, 5 no done
    always @(posedge clk_in) begin
        step <= {step[0], req_in};
        tx_done_out <= req_in && mode_in != 3'd5;
        ack_out <= step[0] && (mode_in == 3'd0 || mode_in == 3'd2 || mode_in == 3'd4);
        nak_out <= step[0] && mode_in == 3'd1;
        rsp_out <= step[1] && mode_in == 3'd0;
        nak_sent_out <= step[1] && mode_in == 3'd2;
        // fields toggle outside the reply so stale values never look valid
        sts_out <= step[1] ? sts_in : ~sts_out;
        ext_out <= step[1] ? ext_in : ~ext_out;
        len_out <= step[1] ? len_in : ~len_out;
    end
endmodule

// ===== verif/tb.sv
// self-checking bench for the command status block
`timescale 1ns/1ns
`include "cmd_status_consts.vh"
`define CHK(got, want) begin total_checks = total_checks + 1; if ((got) !== (want)) begin \
    n_mismatch = n_mismatch + 1; $display("unexpected %0t: %h not %h", $time, got, want); end end
module tb;
    localparam [143:0] EXTS = 144'h01020304050607090a0b101112171a1b1e1f;
    reg clk_in = 1'b0, reset_n_in = 1'b0, list_go_in = 1'b0, cts_in = 1'b1, bad_len = 1'b0;
    reg [3:0] list_len_in = 4'h1, result_idx_in = 4'h0;
    reg [2:0] mode = 3'd0;
    reg [7:0] p_sts = 8'h00, p_ext = 8'h00;
    integer n_mismatch = 0, total_checks = 0;
    wire [15:0] entry_db_addr_in, db_addr_out, net_service_out, result_word_out;
    wire [7:0] entry_count_in, req_count_out, remote_status_code_in, extended_status_byte_in;
    wire [7:0] rsp_len_in, p_len;
    wire [3:0] entry_idx_out;
    wire entry_is_write_in, list_busy_out, req_start_out, req_write_out, tx_done_in, ack_in;
    wire nak_in, rsp_valid_in, nak_sent_in, db_rd_out, db_wr_out, result_strobe_out;
    // entry table: apart database words per entry, odd entries write
    assign entry_db_addr_in = {12'h100, entry_idx_out};
    assign entry_count_in = 8'h04;
    assign entry_is_write_in = entry_idx_out[0];
    assign p_len = bad_len ? 8'h03 : (req_write_out ? 8'h00 : 8'h04);
    always #5 clk_in = ~clk_in;
    cmd_status i_dut (.clk_in, .reset_n_in, .list_go_in, .list_len_in, .entry_db_addr_in,
        .entry_count_in, .entry_is_write_in, .entry_idx_out, .list_busy_out, .cts_in,
        .req_start_out, .req_write_out, .req_count_out, .net_service_out, .tx_done_in, .ack_in,
        .nak_in, .rsp_valid_in, .remote_status_code_in, .extended_status_byte_in, .rsp_len_in,
        .nak_sent_in, .db_rd_out, .db_wr_out, .db_addr_out, .result_idx_in, .result_word_out,
        .result_strobe_out);
    link_model i_link (.clk_in(clk_in), .req_in(req_start_out), .mode_in(mode), .sts_in(p_sts),
        .ext_in(p_ext), .len_in(p_len), .tx_done_out(tx_done_in), .ack_out(ack_in),
        .nak_out(nak_in), .rsp_out(rsp_valid_in), .nak_sent_out(nak_sent_in),
        .sts_out(remote_status_code_in), .ext_out(extended_status_byte_in), .len_out(rsp_len_in));
    task give_verdict;
        begin
            if (n_mismatch == 0 && total_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // bounded wait so a stuck walk is reported, not hung on
    task run(input [3:0] len);
        integer n;
        begin
            @(posedge clk_in);
            list_len_in <= len;
            list_go_in <= 1'b1;
            @(posedge clk_in);
            list_go_in <= 1'b0;
            #1;
            n = 0;
            while (list_busy_out !== 1'b0 && n < 300) begin
                @(posedge clk_in);
                #1;
                n = n + 1;
            end
            `CHK(n < 300, 1'b1)
        end
    endtask
    task rd(input [3:0] idx, input [15:0] want);
        begin
            @(posedge clk_in);
            result_idx_in <= idx;
            repeat (2) @(posedge clk_in);
            #1;
            `CHK(result_word_out, want)
        end
    endtask
    task one(input [7:0] s, input [7:0] e, input [15:0] want);
        begin
            p_sts = s;
            p_ext = e;
            run(4'h1);
            rd(4'h0, want);
        end
    endtask
    task t_remote_codes;
        integer i;
        for (i = 1; i < 15; i = i + 1)
            one({i[3:0], 4'h0}, 8'h00, {i[3:0], 12'h000});
    endtask
    task t_ext_codes;
        integer k;
        for (k = 0; k < 18; k = k + 1)
            one(8'hf0, EXTS[8*k +: 8], {8'hf0, EXTS[8*k +: 8]});
    endtask
    task t_link_faults;
        begin
            @(posedge clk_in);
            cts_in <= 1'b0;
            one(8'h00, 8'h00, 16'hffff);
            @(posedge clk_in);
            cts_in <= 1'b1;
            repeat (3) @(posedge clk_in);
            mode = 3'd1;
            one(8'h00, 8'h00, 16'hffec);
            mode = 3'd2;
            one(8'h00, 8'h00, 16'hffeb);
            mode = 3'd3;
            one(8'h00, 8'h00, 16'hfff6);
            mode = 3'd4;
            one(8'h00, 8'h00, 16'hfff5);
            mode = 3'd5;
            one(8'h00, 8'h00, 16'hfffe);
            mode = 3'd0;
            bad_len = 1'b1;
            one(8'h00, 8'h00, 16'hfff4);
            bad_len = 1'b0;
        end
    endtask
    // entry 0 still holds an error; a clean walk must overwrite it
    task t_list_walk;
        begin
            run(4'h3);
            rd(4'h0, 16'h0000);
            rd(4'h1, 16'h0000);
            rd(4'h2, 16'h0000);
            rd(4'h3, 16'h0000);
            `CHK(net_service_out, 16'haf12)
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_remote_codes;
        t_ext_codes;
        t_link_faults;
        t_list_walk;
        give_verdict;
    end
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end
endmodule
